// >>> rtl/freq_stage_pkg.sv
// Constants, field layouts and carrier types of the frequency protection stage.
// Contract
// [R1] Stages time only with a fixed definite delay from start to trip.
// [R2] Stage condition reads as 0 normal, 1 started, 2 tripped, 3 blocked.
// [R3] Readout gives measured frequency over pick-up in thousandths.
// [R4] Readout gives the expected operate time in five millisecond steps.
// [R5] Readout gives signed remaining time to trip while timing.
// [R6] Blocking input is sampled at the start of each processing cycle.
// [R7] Pick-up without blocking asserts start and begins delay timing.
// [R8] Pick-up with blocking asserts blocked and does not time.
// [R9] Blocking after start drops start and releases as on pick-up clear.
// [R10] Blocking raises an event carrying the pick-up frequency values.
// [R11] Forcing mode lets software drive blocking and force each stage status.
// [R12] The blocking source asserts block at least 5 ms before delay expiry.
// [R13] Start, trip, blocked changes make events, ON/OFF selectable for storage.
// [R14] Every stage has its own start, trip and block ON/OFF events.
// [R15] Fault records sit in a circular store of the latest twelve.
// [R16] A record holds time, event, frequency 20 ms before, fault frequency, group.
// [R17] Eight setting groups are chosen from one common selection input.
// [R18] With the function active each stage is enabled on its own.
// [R19] Zero delay gives start and trip events with the same time stamp.
// [R20] Events carry a time stamp with one millisecond resolution.
// [R21] Start, trip and blocked each have a clearable cumulative counter.
// [R22] Stages release with a fixed 20 mHz hysteresis around pick-up.
// [R23] Over stages pick up above setting, under stages below setting.
// [R24] The timer steps each processing cycle and trips on reaching the delay.
package freq_stage_pkg;

  // ----------------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------------
  localparam int NUM_STAGES = 8;
  localparam int NUM_OVER = 4;
  localparam int NUM_RECORDS = 12;
  localparam int CLK_HZ = 25000000;
  localparam int PROG_CYCLE_US = 5000;
  localparam int TSTAMP_US = 1000;
  localparam int PROG_CYCLE_CLKS = CLK_HZ / 1000000 * PROG_CYCLE_US;
  localparam int TSTAMP_CLKS = CLK_HZ / 1000000 * TSTAMP_US;
  localparam int PRETRIG_MS = 20;
  localparam int PRETRIG_DEPTH = PRETRIG_MS * 1000 / PROG_CYCLE_US;
  localparam int FREQ_LSB_MHZ = 10;
  localparam int HYST_MHZ = 20;
  localparam logic [15:0] HYST_STEPS = 16'(HYST_MHZ / FREQ_LSB_MHZ);
  localparam logic [31:0] RATIO_SCALE = 32'h0000_03e8;

  // ----------------------------------------------------------------------
  // Reset values of the settings
  // ----------------------------------------------------------------------
  localparam logic [15:0] PICKUP_OVER_RST = 16'h13ec;
  localparam logic [15:0] PICKUP_UNDER_RST = 16'h1324;
  localparam logic [18:0] DELAY_RST = 19'h00014;

  // ----------------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FORCE = 8'h04;
  localparam logic [7:0] ADDR_EVSEL = 8'h08;
  localparam logic [7:0] ADDR_CNT_CLEAR = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CNT_START = 8'h14;
  localparam logic [7:0] ADDR_CNT_TRIP = 8'h18;
  localparam logic [7:0] ADDR_CNT_BLOCK = 8'h1c;
  localparam logic [7:0] ADDR_SEL_STAGE = 8'h20;
  localparam logic [7:0] ADDR_SET_INDEX = 8'h24;
  localparam logic [7:0] ADDR_SET_PICKUP = 8'h28;
  localparam logic [7:0] ADDR_SET_DELAY = 8'h2c;
  localparam logic [7:0] ADDR_RATIO = 8'h30;
  localparam logic [7:0] ADDR_EXPECT = 8'h34;
  localparam logic [7:0] ADDR_REMAIN = 8'h38;
  localparam logic [7:0] ADDR_REC_INDEX = 8'h3c;
  localparam logic [7:0] ADDR_REC_TIME = 8'h40;
  localparam logic [7:0] ADDR_REC_INFO = 8'h44;
  localparam logic [7:0] ADDR_REC_FREQ = 8'h48;
  localparam int CTRL_ACTIVE_BIT = 0;
  localparam int CTRL_EN_LSB = 8;
  localparam int CTRL_FORCE_BIT = 16;
  localparam int CTRL_FBLK_LSB = 24;
  localparam int SET_USED_BIT = 31;
  localparam int CLR_START_BIT = 0;
  localparam int CLR_TRIP_BIT = 1;
  localparam int CLR_BLOCK_BIT = 2;

  // ----------------------------------------------------------------------
  // Codes and carriers
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    COND_NORMAL = 2'h0,
    COND_STARTED = 2'h1,
    COND_TRIPPED = 2'h2,
    COND_BLOCKED = 2'h3
  } cond_type;

  // Event kinds index the mask array of an event report.
  localparam int EV_START_ON = 0;
  localparam int EV_START_OFF = 1;
  localparam int EV_TRIP_ON = 2;
  localparam int EV_TRIP_OFF = 3;
  localparam int EV_BLOCK_ON = 4;
  localparam int EV_BLOCK_OFF = 5;

  typedef struct packed {
    logic valid;
    logic [5:0][7:0] mask;
    logic [31:0] tstamp;
    logic [15:0] freq_pre;
    logic [15:0] freq_now;
  } event_type;

  typedef struct packed {
    logic [31:0] tstamp;
    logic [2:0] stage;
    logic [1:0] kind;
    logic [15:0] freq_pre;
    logic [15:0] freq_fault;
    logic [2:0] group;
  } record_type;

endpackage : freq_stage_pkg

// >>> rtl/frequency_function_block.sv
// Over- and under-frequency protection stages with an APB register port.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module frequency_function_block #(
  parameter int PROG_CYCLE_CLKS = freq_stage_pkg::PROG_CYCLE_CLKS,
  parameter int TSTAMP_CLKS = freq_stage_pkg::TSTAMP_CLKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] freq_meas,
  input wire logic [7:0] block_in,
  input wire logic [2:0] group_sel,
  output logic [7:0] stage_start,
  output logic [7:0] stage_trip,
  output logic [7:0] stage_blocked,
  output freq_stage_pkg::event_type event_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic active;
    logic [7:0] stage_en;
    logic force_en;
    logic [7:0] force_blk;
    logic [7:0][1:0] force_code;
    logic [5:0] evsel;
    logic [2:0] sel_stage;
    logic [5:0] set_index;
    logic [3:0] rec_index;
    logic [63:0][15:0] pickup;
    logic [63:0][18:0] delay;
    logic [63:0] used;
    logic [16:0] cyc_div;
    logic [16:0] ms_div;
    logic [31:0] tstamp;
    logic [7:0] blk_meta;
    logic [7:0] blk_sync;
    logic [7:0] start;
    logic [7:0] trip;
    logic [7:0] blocked;
    logic [7:0][18:0] elapsed;
    logic [3:0][15:0] hist;
    logic [31:0] cnt_start;
    logic [31:0] cnt_trip;
    logic [31:0] cnt_block;
    logic [11:0] rec_used;
    logic [3:0] rec_wr;
    freq_stage_pkg::event_type ev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_type;

  state_type s_q;
  state_type s_d;
  freq_stage_pkg::record_type records_q [freq_stage_pkg::NUM_RECORDS];
  freq_stage_pkg::record_type rec_new;
  logic rec_write;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------

  // Settings come up at their defaults: 51 Hz over, 49 Hz under, 0.1 s.
  function automatic state_type reset_value();
    state_type r;
    r = '0;
    for (int k = 0; k < 64; k++)
    begin
      r.pickup[k] = (k % freq_stage_pkg::NUM_STAGES
                     < freq_stage_pkg::NUM_OVER)
                    ? freq_stage_pkg::PICKUP_OVER_RST
                    : freq_stage_pkg::PICKUP_UNDER_RST;
      r.delay[k] = freq_stage_pkg::DELAY_RST;
    end
    return r;
  endfunction : reset_value

  // Address decode shared by the read mux and the write path.
  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= freq_stage_pkg::ADDR_REC_FREQ);
  endfunction : is_mapped

  // Condition code of one stage from its three outputs.
  function automatic logic [1:0] cond_of(input logic st, input logic tr,
                                         input logic bl);
    if (bl)
      return freq_stage_pkg::COND_BLOCKED;
    else if (tr)
      return freq_stage_pkg::COND_TRIPPED;
    else if (st)
      return freq_stage_pkg::COND_STARTED;
    return freq_stage_pkg::COND_NORMAL;
  endfunction : cond_of

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------

  // One pass handles the bus, the dividers, every stage and the records.
  always_comb
  begin
    logic prog_tick;
    logic ms_tick;
    logic wr_en;
    logic [2:0] clr;
    logic [5:0] idx;
    logic [15:0] thr;
    logic [18:0] dly;
    logic [18:0] n_el;
    logic en;
    logic held;
    logic pick;
    logic blk;
    logic n_start;
    logic n_trip;
    logic n_blk;
    logic [1:0] fc;
    logic [31:0] inc_s;
    logic [31:0] inc_t;
    logic [31:0] inc_b;
    logic [31:0] rd;
    logic [15:0] fnow;
    freq_stage_pkg::record_type rec;
    prog_tick = 1'b0;
    ms_tick = 1'b0;
    wr_en = 1'b0;
    clr = 3'h0;
    idx = 6'h00;
    thr = 16'h0000;
    dly = 19'h00000;
    n_el = 19'h00000;
    en = 1'b0;
    held = 1'b0;
    pick = 1'b0;
    blk = 1'b0;
    n_start = 1'b0;
    n_trip = 1'b0;
    n_blk = 1'b0;
    fc = 2'h0;
    inc_s = 32'h0;
    inc_t = 32'h0;
    inc_b = 32'h0;
    rd = 32'h0;
    fnow = freq_meas;
    rec = '0;
    rec_write = 1'b0;
    s_d = s_q;
    s_d.ev.valid = 1'b0;

    // Block inputs come from another domain, so two flops precede use.
    s_d.blk_meta = block_in;
    s_d.blk_sync = s_q.blk_meta;

    // Program cycle and millisecond enables from free running dividers.
    prog_tick = (s_q.cyc_div == 17'(PROG_CYCLE_CLKS - 1));
    ms_tick = (s_q.ms_div == 17'(TSTAMP_CLKS - 1));
    s_d.cyc_div = prog_tick ? 17'h0 : s_q.cyc_div + 17'h1;
    s_d.ms_div = ms_tick ? 17'h0 : s_q.ms_div + 17'h1;
    if (ms_tick)
      s_d.tstamp = s_q.tstamp + 32'h1; // [R20]

    // Bus: data is latched in the setup cycle so the answer is a flop.
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    idx = {group_sel, s_q.sel_stage};
    if (psel && !penable)
    begin
      s_d.pready = 1'b1;
      s_d.pslverr = !is_mapped(paddr);
      case (paddr)
        freq_stage_pkg::ADDR_CTRL:
          rd = {s_q.force_blk, 7'h0, s_q.force_en, s_q.stage_en, 7'h0,
                s_q.active};
        freq_stage_pkg::ADDR_FORCE: rd = {16'h0, s_q.force_code};
        freq_stage_pkg::ADDR_EVSEL: rd = {26'h0, s_q.evsel};
        freq_stage_pkg::ADDR_STATUS:
          for (int i = 0; i < freq_stage_pkg::NUM_STAGES; i++)
            rd[2*i +: 2] = cond_of(s_q.start[i], s_q.trip[i],
                                   s_q.blocked[i]); // [R2]
        freq_stage_pkg::ADDR_CNT_START: rd = s_q.cnt_start;
        freq_stage_pkg::ADDR_CNT_TRIP: rd = s_q.cnt_trip;
        freq_stage_pkg::ADDR_CNT_BLOCK: rd = s_q.cnt_block;
        freq_stage_pkg::ADDR_SEL_STAGE: rd = {29'h0, s_q.sel_stage};
        freq_stage_pkg::ADDR_SET_INDEX: rd = {26'h0, s_q.set_index};
        freq_stage_pkg::ADDR_SET_PICKUP:
          rd = {16'h0, s_q.pickup[s_q.set_index]};
        freq_stage_pkg::ADDR_SET_DELAY:
          rd = {s_q.used[s_q.set_index], 12'h0, s_q.delay[s_q.set_index]};
        // A zero pick-up would divide by zero, so it reads as zero.
        freq_stage_pkg::ADDR_RATIO:
          rd = (s_q.pickup[idx] == 16'h0) ? 32'h0
             : ({16'h0, s_q.hist[0]} * freq_stage_pkg::RATIO_SCALE)
               / {16'h0, s_q.pickup[idx]}; // [R3]
        freq_stage_pkg::ADDR_EXPECT:
          rd = {13'h0, s_q.delay[idx]}; // [R4]
        freq_stage_pkg::ADDR_REMAIN:
          rd = {13'h0, s_q.delay[idx]}
             - {13'h0, s_q.elapsed[s_q.sel_stage]}; // [R5]
        freq_stage_pkg::ADDR_REC_INDEX: rd = {28'h0, s_q.rec_index};
        freq_stage_pkg::ADDR_REC_TIME:
          rd = records_q[s_q.rec_index].tstamp; // [R16]
        freq_stage_pkg::ADDR_REC_INFO:
          rd = {s_q.rec_used[s_q.rec_index], 20'h0,
                records_q[s_q.rec_index].group,
                3'h0, records_q[s_q.rec_index].kind,
                records_q[s_q.rec_index].stage}; // [R16]
        freq_stage_pkg::ADDR_REC_FREQ:
          rd = {records_q[s_q.rec_index].freq_fault,
                records_q[s_q.rec_index].freq_pre}; // [R16]
        default: rd = 32'h0;
      endcase
      s_d.prdata = rd;
    end

    // A write takes effect on the access edge that the slave answers.
    wr_en = psel && penable && s_q.pready && pwrite && is_mapped(paddr);
    if (wr_en)
    begin
      case (paddr)
        freq_stage_pkg::ADDR_CTRL:
        begin
          s_d.active = pwdata[freq_stage_pkg::CTRL_ACTIVE_BIT];
          s_d.stage_en = pwdata[freq_stage_pkg::CTRL_EN_LSB +: 8]; // [R18]
          s_d.force_en = pwdata[freq_stage_pkg::CTRL_FORCE_BIT]; // [R11]
          s_d.force_blk = pwdata[freq_stage_pkg::CTRL_FBLK_LSB +: 8];
        end
        freq_stage_pkg::ADDR_FORCE: s_d.force_code = pwdata[15:0]; // [R11]
        freq_stage_pkg::ADDR_EVSEL: s_d.evsel = pwdata[5:0]; // [R13]
        freq_stage_pkg::ADDR_CNT_CLEAR:
          clr = {pwdata[freq_stage_pkg::CLR_BLOCK_BIT],
                 pwdata[freq_stage_pkg::CLR_TRIP_BIT],
                 pwdata[freq_stage_pkg::CLR_START_BIT]};
        freq_stage_pkg::ADDR_SEL_STAGE: s_d.sel_stage = pwdata[2:0];
        freq_stage_pkg::ADDR_SET_INDEX: s_d.set_index = pwdata[5:0]; // [R17]
        freq_stage_pkg::ADDR_SET_PICKUP:
          s_d.pickup[s_q.set_index] = pwdata[15:0];
        freq_stage_pkg::ADDR_SET_DELAY:
        begin
          s_d.delay[s_q.set_index] = pwdata[18:0]; // [R1]
          s_d.used[s_q.set_index] = pwdata[freq_stage_pkg::SET_USED_BIT];
        end
        freq_stage_pkg::ADDR_REC_INDEX:
          s_d.rec_index = (pwdata[3:0] < 4'(freq_stage_pkg::NUM_RECORDS))
                        ? pwdata[3:0] : 4'h0;
        default: s_d.rec_index = s_q.rec_index;
      endcase
    end

    // Stages are evaluated once per program cycle.
    if (prog_tick)
    begin
      s_d.hist = {s_q.hist[2:0], fnow};
      s_d.ev.valid = 1'b1;
      s_d.ev.tstamp = s_q.tstamp; // [R19]
      s_d.ev.freq_pre = s_q.hist[freq_stage_pkg::PRETRIG_DEPTH - 1]; // [R10]
      s_d.ev.freq_now = fnow;
      for (int i = 0; i < freq_stage_pkg::NUM_STAGES; i++)
      begin
        idx = {group_sel, 3'(i)}; // [R17]
        thr = s_q.pickup[idx];
        dly = s_q.delay[idx];
        en = s_q.active && s_q.stage_en[i] && s_q.used[idx]; // [R18]
        held = s_q.start[i] || s_q.trip[i] || s_q.blocked[i];
        // Once picked up, the threshold moves back by the hysteresis.
        if (i < freq_stage_pkg::NUM_OVER)
          pick = held ? (fnow > thr - freq_stage_pkg::HYST_STEPS)
                      : (fnow > thr); // [R23] [R22]
        else
          pick = held ? (fnow < thr + freq_stage_pkg::HYST_STEPS)
                      : (fnow < thr); // [R23] [R22]
        blk = s_q.force_en ? s_q.force_blk[i] : s_q.blk_sync[i]; // [R6] [R11]
        n_start = 1'b0;
        n_trip = 1'b0;
        n_blk = 1'b0;
        n_el = 19'h0;
        if (en && pick)
        begin
          if (blk)
            n_blk = 1'b1; // [R8] [R9]
          else
          begin
            n_start = 1'b1; // [R7]
            if (s_q.start[i])
              n_el = (s_q.elapsed[i] < dly) ? s_q.elapsed[i] + 19'h1
                                            : s_q.elapsed[i]; // [R24]
            n_trip = (n_el >= dly); // [R1] [R24] [R19]
          end
        end
        fc = s_q.force_code[i];
        if (s_q.force_en && fc != freq_stage_pkg::COND_NORMAL)
        begin
          n_start = (fc == freq_stage_pkg::COND_STARTED)
                 || (fc == freq_stage_pkg::COND_TRIPPED); // [R11]
          n_trip = (fc == freq_stage_pkg::COND_TRIPPED);
          n_blk = (fc == freq_stage_pkg::COND_BLOCKED);
        end
        s_d.start[i] = n_start;
        s_d.trip[i] = n_trip;
        s_d.blocked[i] = n_blk;
        s_d.elapsed[i] = n_el;
        // Each edge is an event, kept only where its selection bit is set.
        s_d.ev.mask[freq_stage_pkg::EV_START_ON][i] =
          n_start && !s_q.start[i] && s_q.evsel[0]; // [R13] [R14]
        s_d.ev.mask[freq_stage_pkg::EV_START_OFF][i] =
          !n_start && s_q.start[i] && s_q.evsel[1]; // [R13] [R14]
        s_d.ev.mask[freq_stage_pkg::EV_TRIP_ON][i] =
          n_trip && !s_q.trip[i] && s_q.evsel[2]; // [R13] [R14]
        s_d.ev.mask[freq_stage_pkg::EV_TRIP_OFF][i] =
          !n_trip && s_q.trip[i] && s_q.evsel[3]; // [R13] [R14]
        s_d.ev.mask[freq_stage_pkg::EV_BLOCK_ON][i] =
          n_blk && !s_q.blocked[i] && s_q.evsel[4]; // [R10] [R14]
        s_d.ev.mask[freq_stage_pkg::EV_BLOCK_OFF][i] =
          !n_blk && s_q.blocked[i] && s_q.evsel[5]; // [R13] [R14]
        inc_s = inc_s + {31'h0, n_start && !s_q.start[i]};
        inc_t = inc_t + {31'h0, n_trip && !s_q.trip[i]};
        inc_b = inc_b + {31'h0, n_blk && !s_q.blocked[i]};
      end
      // Only one record per cycle: a trip beats a start, low stages first.
      for (int i = freq_stage_pkg::NUM_STAGES - 1; i >= 0; i--)
      begin
        if (s_d.start[i] && !s_q.start[i])
        begin
          rec_write = 1'b1;
          rec.stage = 3'(i);
          rec.kind = freq_stage_pkg::COND_STARTED;
        end
      end
      for (int i = freq_stage_pkg::NUM_STAGES - 1; i >= 0; i--)
      begin
        if (s_d.trip[i] && !s_q.trip[i])
        begin
          rec_write = 1'b1;
          rec.stage = 3'(i);
          rec.kind = freq_stage_pkg::COND_TRIPPED;
        end
      end
      rec.tstamp = s_q.tstamp; // [R16]
      rec.freq_pre = s_q.hist[freq_stage_pkg::PRETRIG_DEPTH - 1]; // [R16]
      rec.freq_fault = fnow;
      rec.group = group_sel;
      if (rec_write)
      begin
        s_d.rec_used[s_q.rec_wr] = 1'b1;
        s_d.rec_wr = (s_q.rec_wr == 4'(freq_stage_pkg::NUM_RECORDS - 1))
                   ? 4'h0 : s_q.rec_wr + 4'h1; // [R15]
      end
    end

    // A clear in the same cycle as a new occurrence still counts it.
    s_d.cnt_start = (clr[0] ? 32'h0 : s_q.cnt_start) + inc_s; // [R21]
    s_d.cnt_trip = (clr[1] ? 32'h0 : s_q.cnt_trip) + inc_t; // [R21]
    s_d.cnt_block = (clr[2] ? 32'h0 : s_q.cnt_block) + inc_b; // [R21]
    rec_new = rec;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------

  // All state of the block except the record store in one register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= reset_value();
    else
      s_q <= s_d;
  end

  // Record store is written in place, so it needs no reset.
  always_ff @(posedge pclk)
  begin
    if (rec_write)
      records_q[s_q.rec_wr] <= rec_new; // [R15]
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign stage_start = s_q.start;
  assign stage_trip = s_q.trip;
  assign stage_blocked = s_q.blocked;
  assign event_out = s_q.ev;

endmodule : frequency_function_block

// >>> dv/freq_stage_monitor.sv
// Checker of the frequency stage block ports.
`timescale 1ns/1ps
module freq_stage_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] stage_start,
  input wire logic [7:0] stage_trip,
  input wire logic [7:0] stage_blocked,
  input freq_stage_pkg::event_type event_out
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The bus answers in the first access cycle, never outside one.
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access cycle");
  a_err_unmapped: assert property (pready && paddr > 8'h48 |-> pslverr)
    else $error("unmapped address answered without error");
  // A blocked stage never shows start as well.
  a_blocked_no_start: assert property (
    (stage_start & stage_blocked) == 8'h00)
    else $error("start and blocked together");
  // Event bits must agree with the outputs they report.
  a_start_on_mask: assert property (event_out.valid |->
    (event_out.mask[freq_stage_pkg::EV_START_ON] & ~stage_start) == 8'h00)
    else $error("start on event without start");
  a_start_off_mask: assert property (event_out.valid |->
    (event_out.mask[freq_stage_pkg::EV_START_OFF] & stage_start) == 8'h00)
    else $error("start off event with start high");
  a_trip_on_mask: assert property (event_out.valid |->
    (event_out.mask[freq_stage_pkg::EV_TRIP_ON] & ~stage_trip) == 8'h00)
    else $error("trip on event without trip");
  a_block_on_mask: assert property (event_out.valid |->
    (event_out.mask[freq_stage_pkg::EV_BLOCK_ON] & ~stage_blocked) == 8'h00)
    else $error("block on event without blocked");
  a_valid_pulse: assert property (event_out.valid |=> !event_out.valid)
    else $error("event valid longer than one cycle");
endmodule : freq_stage_monitor

// >>> dv/block_source.sv
// Blocking matrix and event store model at the far side of the stages.
`timescale 1ns/1ps
module block_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] block_req,
  input freq_stage_pkg::event_type event_out,
  output logic [7:0] block_in,
  output logic [15:0] ev_count
);
  // Block follows the request one edge later, well ahead of any delay
  // expiry, because a late block cannot stop a trip.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      block_in <= 8'h00;
      ev_count <= 16'h0000;
    end
    else
    begin
      block_in <= block_req;
      if (event_out.valid && event_out.mask != '0)
        ev_count <= ev_count + 16'h0001;
    end
  end
endmodule : block_source

// >>> dv/testbench.sv
// Self-checking bench of the frequency stage block.
`timescale 1ns/1ps
module testbench;
  localparam int PC = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] freq_meas = 16'h1388;
  logic [7:0] block_req = 8'h00;
  logic [7:0] block_in;
  logic [2:0] group_sel = 3'h0;
  logic [7:0] stage_start;
  logic [7:0] stage_trip;
  logic [7:0] stage_blocked;
  logic [15:0] ev_count;
  freq_stage_pkg::event_type event_out;
  logic [32:0] exp_q[$];
  int err_count = 0;
  int total_checks = 0;
  int n;
  frequency_function_block #(.PROG_CYCLE_CLKS(PC), .TSTAMP_CLKS(4))
    frequency_function_block_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .freq_meas(freq_meas), .block_in(block_in), .group_sel(group_sel),
    .stage_start(stage_start), .stage_trip(stage_trip),
    .stage_blocked(stage_blocked), .event_out(event_out));
  block_source block_source_i (.pclk(pclk), .presetn(presetn),
    .block_req(block_req), .event_out(event_out), .block_in(block_in),
    .ev_count(ev_count));
  // Clock of 40 ns period.
  always #20 pclk = ~pclk;
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One transfer; an idle cycle follows so psel is never set twice at once.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Bounded wait for one stage output level.
  task automatic await(input int w, input int i, input logic v);
    logic s;
    int k;
    k = 0;
    do
    begin
      @(negedge pclk);
      s = (w == 0) ? stage_start[i] : (w == 1) ? stage_trip[i]
        : stage_blocked[i];
      k++;
    end
    while (s !== v && k < PC * 12);
    check(33'(s), 33'(v));
    @(posedge pclk);
  endtask : await
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // Read data is taken at the edge that samples pready high.
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      check({pslverr, prdata}, exp_q.pop_front());
  initial
  begin
    #(40 * 40000);
    err_count++;
    wrap_up;
  end
  initial
  begin
    logic [2:0] g;
    int d;
    void'($urandom(32'hfb73));
    g = 3'($urandom_range(7));
    d = int'($urandom_range(5, 2));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    group_sel <= g;
    @(posedge pclk);
    rd(freq_stage_pkg::ADDR_CTRL, 33'h0);
    apb(1'b1, freq_stage_pkg::ADDR_SET_INDEX, {26'h0, g, 3'h0});
    rd(freq_stage_pkg::ADDR_SET_PICKUP, 33'h13ec);
    rd(freq_stage_pkg::ADDR_SET_DELAY, 33'h14);
    apb(1'b1, freq_stage_pkg::ADDR_SET_PICKUP, 32'h1388);
    apb(1'b1, freq_stage_pkg::ADDR_SET_DELAY, 32'h8000_0000 | d);
    apb(1'b1, freq_stage_pkg::ADDR_SET_INDEX, {26'h0, g, 3'h4});
    rd(freq_stage_pkg::ADDR_SET_PICKUP, 33'h1324);
    apb(1'b1, freq_stage_pkg::ADDR_SET_DELAY, 32'h8000_0000);
    rd(8'h4c, 33'h1_0000_0000);
    apb(1'b1, freq_stage_pkg::ADDR_EVSEL, 32'h3f);
    apb(1'b1, freq_stage_pkg::ADDR_CTRL, 32'h1101);
    // Over-frequency pick-up, then the definite delay in program ticks.
    freq_meas <= 16'h1389;
    await(0, 0, 1'b1);
    n = 0;
    repeat (PC * 12)
    begin
      @(negedge pclk);
      n += int'(event_out.valid === 1'b1);
      if (stage_trip[0] === 1'b1)
        break;
    end
    check(33'(n), 33'(d));
    @(posedge pclk);
    rd(freq_stage_pkg::ADDR_STATUS, 33'h2);
    apb(1'b1, freq_stage_pkg::ADDR_SEL_STAGE, 32'h0);
    rd(freq_stage_pkg::ADDR_RATIO, 33'h3e8);
    rd(freq_stage_pkg::ADDR_EXPECT, 33'(d));
    rd(freq_stage_pkg::ADDR_REMAIN, 33'h0);
    // Inside the hysteresis band the trip holds; at its edge it releases.
    freq_meas <= 16'h1387;
    repeat (3 * PC) @(posedge pclk);
    check(33'(stage_trip[0]), 33'h1);
    freq_meas <= 16'h1386;
    await(0, 0, 1'b0);
    rd(freq_stage_pkg::ADDR_CNT_START, 33'h1);
    rd(freq_stage_pkg::ADDR_CNT_TRIP, 33'h1);
    // Block first, then block arriving after start.
    block_req <= 8'h01;
    repeat (5) @(posedge pclk);
    freq_meas <= 16'h1389;
    await(2, 0, 1'b1);
    rd(freq_stage_pkg::ADDR_CNT_START, 33'h1);
    rd(freq_stage_pkg::ADDR_CNT_BLOCK, 33'h1);
    block_req <= 8'h00;
    await(0, 0, 1'b1);
    block_req <= 8'h01;
    await(0, 0, 1'b0);
    check(33'(stage_trip[0]), 33'h0);
    apb(1'b1, freq_stage_pkg::ADDR_CNT_CLEAR, 32'h7);
    rd(freq_stage_pkg::ADDR_CNT_START, 33'h0);
    rd(freq_stage_pkg::ADDR_CNT_BLOCK, 33'h0);
    // Under-frequency stage with zero delay trips at its start.
    block_req <= 8'h00;
    freq_meas <= 16'h1323;
    await(0, 4, 1'b1);
    check(33'(stage_trip[4]), 33'h1);
    check(33'(ev_count != 16'h0), 33'h1);
    wrap_up;
  end
endmodule : testbench
bind frequency_function_block freq_stage_monitor freq_stage_monitor_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .stage_start(stage_start), .stage_trip(stage_trip),
  .stage_blocked(stage_blocked), .event_out(event_out));
